// ==== core/ssr_pkg.sv ====
// Shared constants and types of the status and service request block.
// Assumes a single pclk domain and an APB master with 32-bit data.
package ssr_pkg;
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_STD_EN    = 8'h04;
  localparam logic [7:0] A_STD_EVT   = 8'h08;
  localparam logic [7:0] A_SRQ_EN    = 8'h0c;
  localparam logic [7:0] A_STB       = 8'h10;
  localparam logic [7:0] A_SPOLL     = 8'h14;
  localparam logic [7:0] A_QUEUE     = 8'h18;
  localparam logic [7:0] A_OPERATION_SUMMARY_BASE = 8'h1c;
  localparam logic [7:0] A_QUESTIONABLE_SUMMARY_BASE = 8'h30;
  localparam logic [7:0] A_DIG_DATA  = 8'h44;
  localparam logic [7:0] A_INH_STAT  = 8'h48;
  // Group layout relative to its base
  localparam logic [7:0] G_COND      = 8'h00;
  localparam logic [7:0] G_RISE      = 8'h04;
  localparam logic [7:0] G_FALL      = 8'h08;
  localparam logic [7:0] G_EVENT     = 8'h0c;
  localparam logic [7:0] G_ENABLE    = 8'h10;

  localparam int         STB_QUESTIONABLE_SUMMARY    = 3;
  localparam int         STB_MSG     = 4;
  localparam int         STB_ESB     = 5;
  localparam int         STB_MSS     = 6;
  localparam int         STB_OPERATION_SUMMARY    = 7;
  localparam int         POWER_ON_BIT = 7;

  localparam int         GRP_W       = 16;
  localparam int         QUEUE_DEPTH = 8;
  localparam int         QUEUE_AW    = 3;
  localparam int         DIG_W       = 3;

  typedef enum logic [1:0] {
    INH_LATCHED = 2'h0,
    INH_LIVE    = 2'h1,
    INH_OFF     = 2'h2
  } ssr_inh_mode_e;

  typedef enum logic [2:0] {
    FSRC_QUESTIONABLE_SUMMARY = 3'h0,
    FSRC_OPERATION_SUMMARY = 3'h1,
    FSRC_ESB  = 3'h2,
    FSRC_RQS  = 3'h3,
    FSRC_OFF  = 3'h4
  } ssr_fault_src_e;

  typedef struct packed {
    logic           flt_en;
    ssr_fault_src_e flt_src;
    ssr_inh_mode_e  inh_mode;
    logic           dig_mode;
    logic           psc;
  } ssr_ctrl_s;

  localparam ssr_ctrl_s CTRL_RESET = '{flt_en: 1'b0, flt_src: FSRC_OFF,
                                       inh_mode: INH_OFF, dig_mode: 1'b0, psc: 1'b1};

  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_RUN  = 2'h1
  } ssr_state_e;
endpackage

// ==== core/ssr_group.sv ====
// One status group: condition, edge filters, sticky events, enable, summary.
// Assumes cond is already synchronised to pclk.
module ssr_group
  import ssr_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [GRP_W-1:0] cond,
  input  wire logic             wr_rise,
  input  wire logic             wr_fall,
  input  wire logic             wr_enable,
  input  wire logic [GRP_W-1:0] wdata,
  input  wire logic             rd_clear,
  output logic      [GRP_W-1:0] cond_q,
  output logic      [GRP_W-1:0] rise_q,
  output logic      [GRP_W-1:0] fall_q,
  output logic      [GRP_W-1:0] event_q,
  output logic      [GRP_W-1:0] enable_q,
  output logic                  summary
);
  logic [GRP_W-1:0] hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_q   <= '0;
      fall_q   <= '0;
      enable_q <= '0;
    end else begin
      if (wr_rise) begin
        rise_q <= wdata;
      end
      if (wr_fall) begin
        fall_q <= wdata;
      end
      if (wr_enable) begin
        enable_q <= wdata;
      end
    end
  end

  // Compare successive condition samples
  assign hit = (rise_q & cond & ~cond_q) | (fall_q & ~cond & cond_q);

  // New edges win over a read-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= '0;
    end else if (rd_clear) begin
      event_q <= hit;
    end else begin
      event_q <= event_q | hit;
    end
  end

  assign summary = |(event_q & enable_q);
endmodule

// ==== core/ssr_top.sv ====
// Status byte, standard events, service request and rear port of the source.
// Assumes APB in the pclk domain; conditions and pins arrive asynchronously.
module ssr_top
  import ssr_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        std_events,
  input  wire logic [GRP_W-1:0]  operation_summary_cond_in,
  input  wire logic [GRP_W-1:0]  questionable_summary_cond_in,
  input  wire logic              saved_psc,
  input  wire logic [7:0]        saved_std_en,
  output logic                   keep_psc,
  output logic      [7:0]        keep_std_en,
  input  wire logic [DIG_W-1:0]  port_in,
  output logic      [DIG_W-1:0]  port_out,
  output logic      [DIG_W-1:0]  port_oe,
  output logic                   srq,
  output logic                   output_disable
);
  ssr_state_e        state_reg;
  ssr_ctrl_s         ctrl_reg;
  logic [7:0]        std_en_reg;
  logic [7:0]        std_evt_reg;
  logic [7:0]        srq_en_reg;
  logic              rqs_reg;
  logic              mss_reg;
  logic [DIG_W-1:0]  dig_reg;
  logic              inh_latch_reg;
  logic [GRP_W-1:0]  operation_summary_s1, operation_summary_s2, questionable_summary_s1, questionable_summary_s2;
  logic [DIG_W-1:0]  pin_s1, pin_s2;
  logic [7:0]        queue_mem [QUEUE_DEPTH];
  logic [QUEUE_AW-1:0] wr_ptr, rd_ptr;
  logic [QUEUE_AW:0] q_count;

  logic              access, setup;
  logic [31:0]       rd_mux;
  logic              rd_hit;
  logic              operation_summary_sum, questionable_summary_sum, event_summary_bit, master_summary, q_full, q_empty, q_push, q_pop;
  logic [7:0]        stb;
  logic              fault_active, inh_active;
  logic [GRP_W-1:0]  oc, orr, of, oe_, oen, qc, qr, qf, qe, qen;

  function automatic logic is_access(input logic [7:0] a, input logic [7:0] off);
    is_access = (a == off);
  endfunction

  function automatic logic any_set(input logic [7:0] bits, input logic [7:0] mask);
    any_set = |(bits & mask);
  endfunction

  assign setup  = psel & penable & ~pready;
  assign access = psel & penable & pready;

  // Two-flop synchronisers on all asynchronous inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operation_summary_s1 <= '0;
      operation_summary_s2 <= '0;
      questionable_summary_s1 <= '0;
      questionable_summary_s2 <= '0;
      pin_s1  <= '1;
      pin_s2  <= '1;
    end else begin
      operation_summary_s1 <= operation_summary_cond_in;
      operation_summary_s2 <= operation_summary_s1;
      questionable_summary_s1 <= questionable_summary_cond_in;
      questionable_summary_s2 <= questionable_summary_s1;
      pin_s1  <= port_in;
      pin_s2  <= pin_s1;
    end
  end

  ssr_group u_operation_summary (
    .pclk      (pclk),
    .presetn   (presetn),
    .cond      (operation_summary_s2),
    .wr_rise   (access & pwrite & is_access(paddr, A_OPERATION_SUMMARY_BASE + G_RISE)),
    .wr_fall   (access & pwrite & is_access(paddr, A_OPERATION_SUMMARY_BASE + G_FALL)),
    .wr_enable (access & pwrite & is_access(paddr, A_OPERATION_SUMMARY_BASE + G_ENABLE)),
    .wdata     (pwdata[GRP_W-1:0]),
    .rd_clear  (access & ~pwrite & is_access(paddr, A_OPERATION_SUMMARY_BASE + G_EVENT)),
    .cond_q    (oc),
    .rise_q    (orr),
    .fall_q    (of),
    .event_q   (oe_),
    .enable_q  (oen),
    .summary   (operation_summary_sum)
  );

  ssr_group u_questionable_summary (
    .pclk      (pclk),
    .presetn   (presetn),
    .cond      (questionable_summary_s2),
    .wr_rise   (access & pwrite & is_access(paddr, A_QUESTIONABLE_SUMMARY_BASE + G_RISE)),
    .wr_fall   (access & pwrite & is_access(paddr, A_QUESTIONABLE_SUMMARY_BASE + G_FALL)),
    .wr_enable (access & pwrite & is_access(paddr, A_QUESTIONABLE_SUMMARY_BASE + G_ENABLE)),
    .wdata     (pwdata[GRP_W-1:0]),
    .rd_clear  (access & ~pwrite & is_access(paddr, A_QUESTIONABLE_SUMMARY_BASE + G_EVENT)),
    .cond_q    (qc),
    .rise_q    (qr),
    .fall_q    (qf),
    .event_q   (qe),
    .enable_q  (qen),
    .summary   (questionable_summary_sum)
  );

  // Boot step: recover kept settings one cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_BOOT;
    end else begin
      state_reg <= ST_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (state_reg == ST_BOOT) begin
      ctrl_reg.psc <= saved_psc;
    end else if (access & pwrite & is_access(paddr, A_CTRL)) begin
      ctrl_reg <= ssr_ctrl_s'(pwdata[7:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_en_reg <= '0;
    end else if (state_reg == ST_BOOT) begin
      std_en_reg <= saved_psc ? 8'h00 : saved_std_en;
    end else if (access & pwrite & is_access(paddr, A_STD_EN)) begin
      std_en_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_evt_reg <= '0;
    end else if (state_reg == ST_BOOT) begin
      std_evt_reg <= 8'h01 << POWER_ON_BIT;
    end else if (access & ~pwrite & is_access(paddr, A_STD_EVT)) begin
      std_evt_reg <= std_events;
    end else begin
      std_evt_reg <= std_evt_reg | std_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srq_en_reg <= '0;
    end else if (access & pwrite & is_access(paddr, A_SRQ_EN)) begin
      srq_en_reg <= pwdata[7:0];
    end
  end

  // Summary bits are combinational so a read-clear drops them at once
  assign event_summary_bit = any_set(std_evt_reg, std_en_reg);
  always_comb begin
    stb           = 8'h00;
    stb[STB_QUESTIONABLE_SUMMARY] = questionable_summary_sum;
    stb[STB_MSG]  = ~q_empty;
    stb[STB_ESB]  = event_summary_bit;
    stb[STB_OPERATION_SUMMARY] = operation_summary_sum;
  end
  assign master_summary = any_set(stb, srq_en_reg);

  // Request latches on a new rise of the master summary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mss_reg <= 1'b0;
      rqs_reg <= 1'b0;
    end else begin
      mss_reg <= master_summary;
      if (master_summary & ~mss_reg) begin
        rqs_reg <= 1'b1;
      end else if (access & ~pwrite & is_access(paddr, A_SPOLL)) begin
        rqs_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srq <= 1'b0;
    end else begin
      srq <= rqs_reg | (master_summary & ~mss_reg);
    end
  end

  // Output queue; a full queue drops further writes
  assign q_full  = (q_count == (QUEUE_AW + 1)'(QUEUE_DEPTH));
  assign q_empty = (q_count == '0);
  assign q_push  = access & pwrite & is_access(paddr, A_QUEUE) & ~q_full;
  assign q_pop   = access & ~pwrite & is_access(paddr, A_QUEUE) & ~q_empty;

  always_ff @(posedge pclk) begin
    if (q_push) begin
      queue_mem[wr_ptr] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      q_count <= '0;
    end else begin
      if (q_push) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (q_pop) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      q_count <= q_count + {3'h0, q_push} - {3'h0, q_pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_reg <= '1;
    end else if (access & pwrite & is_access(paddr, A_DIG_DATA)) begin
      dig_reg <= pwdata[DIG_W-1:0];
    end
  end

  always_comb begin
    unique case (ctrl_reg.flt_src)
      FSRC_QUESTIONABLE_SUMMARY: fault_active = questionable_summary_sum;
      FSRC_OPERATION_SUMMARY: fault_active = operation_summary_sum;
      FSRC_ESB:  fault_active = event_summary_bit;
      FSRC_RQS:  fault_active = rqs_reg;
      default:   fault_active = 1'b0;
    endcase
    fault_active = fault_active & ctrl_reg.flt_en & ~ctrl_reg.dig_mode;
  end

  // Inhibit pin is active low; only meaningful in inhibit/fault mode
  assign inh_active = ~pin_s2[2] & ~ctrl_reg.dig_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inh_latch_reg <= 1'b0;
    end else if (inh_active & ctrl_reg.inh_mode == INH_LATCHED) begin
      inh_latch_reg <= 1'b1;
    end else if ((access & pwrite & is_access(paddr, A_INH_STAT) & pwdata[0])
                 | ctrl_reg.inh_mode != INH_LATCHED) begin
      inh_latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_disable <= 1'b0;
    end else begin
      unique case (ctrl_reg.inh_mode)
        INH_LATCHED: output_disable <= inh_latch_reg | inh_active;
        INH_LIVE:    output_disable <= inh_active;
        default:     output_disable <= 1'b0;
      endcase
    end
  end

  // Fault lines pull low while active; digital line 2 is open collector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out <= '0;
      port_oe  <= '0;
    end else if (ctrl_reg.dig_mode) begin
      port_out <= {1'b0, dig_reg[1:0]};
      port_oe  <= {~dig_reg[2], 2'b11};
    end else begin
      port_out <= '0;
      port_oe  <= {1'b0, fault_active, fault_active};
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      A_CTRL:                 rd_mux[7:0] = ctrl_reg;
      A_STD_EN:               rd_mux[7:0] = std_en_reg;
      A_STD_EVT:              rd_mux[7:0] = std_evt_reg;
      A_SRQ_EN:               rd_mux[7:0] = srq_en_reg;
      A_STB:                  rd_mux[7:0] = stb | ({7'h00, master_summary} << STB_MSS);
      A_SPOLL:                rd_mux[7:0] = stb | ({7'h00, rqs_reg} << STB_MSS);
      A_QUEUE:                rd_mux[7:0] = q_empty ? 8'h00 : queue_mem[rd_ptr];
      A_OPERATION_SUMMARY_BASE + G_COND:   rd_mux[GRP_W-1:0] = oc;
      A_OPERATION_SUMMARY_BASE + G_RISE:   rd_mux[GRP_W-1:0] = orr;
      A_OPERATION_SUMMARY_BASE + G_FALL:   rd_mux[GRP_W-1:0] = of;
      A_OPERATION_SUMMARY_BASE + G_EVENT:  rd_mux[GRP_W-1:0] = oe_;
      A_OPERATION_SUMMARY_BASE + G_ENABLE: rd_mux[GRP_W-1:0] = oen;
      A_QUESTIONABLE_SUMMARY_BASE + G_COND:   rd_mux[GRP_W-1:0] = qc;
      A_QUESTIONABLE_SUMMARY_BASE + G_RISE:   rd_mux[GRP_W-1:0] = qr;
      A_QUESTIONABLE_SUMMARY_BASE + G_FALL:   rd_mux[GRP_W-1:0] = qf;
      A_QUESTIONABLE_SUMMARY_BASE + G_EVENT:  rd_mux[GRP_W-1:0] = qe;
      A_QUESTIONABLE_SUMMARY_BASE + G_ENABLE: rd_mux[GRP_W-1:0] = qen;
      A_DIG_DATA:             rd_mux[DIG_W-1:0] = pin_s2;
      A_INH_STAT:             rd_mux[1:0] = {inh_active, inh_latch_reg};
      default:                rd_hit = 1'b0;
    endcase
  end

  // One wait state: data captured before the edge that applies side effects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~rd_hit;
      if (setup & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_psc    <= 1'b1;
      keep_std_en <= '0;
    end else begin
      keep_psc    <= ctrl_reg.psc;
      keep_std_en <= std_en_reg;
    end
  end
endmodule

// ==== tb/ssr_chk.sv ====
// Port-level checker of ssr_top: bus timing, request line, rear port.
// Assumes one pclk domain; shadows ctrl and digital data from APB writes.
module ssr_chk
  import ssr_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [DIG_W-1:0]  port_in,
  input wire logic [DIG_W-1:0]  port_out,
  input wire logic [DIG_W-1:0]  port_oe,
  input wire logic              srq,
  input wire logic              output_disable
);
  timeunit 1ns;
  timeprecision 1ps;
  ssr_ctrl_s  ctrl_q;
  logic [7:0] dig_q;
  logic [1:0] quiet;
  wire wr_done   = psel && penable && pready && pwrite && !pslverr;
  wire poll_done = psel && penable && pready && !pwrite && paddr == A_SPOLL;
  // Rear port and output_disable are judged only once two cycles have passed since any error-free write
  wire settled   = quiet[1];
  wire live      = ctrl_q.inh_mode == INH_LIVE && !ctrl_q.dig_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      dig_q  <= 8'h07;
      quiet  <= 2'h0;
    end else begin
      if (wr_done && paddr == A_CTRL) ctrl_q <= ssr_ctrl_s'(pwdata[7:0]);
      if (wr_done && paddr == A_DIG_DATA) dig_q <= pwdata[7:0];
      quiet <= wr_done ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  ready_wait_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without one wait cycle");
  poll_drop_a: assert property (poll_done |-> ##[1:2] !srq)
    else $error("srq still high after serial poll");
  srq_hold_a: assert property (srq && !poll_done && !$past(poll_done) |=> srq)
    else $error("srq dropped without serial poll");
  fault_pins_a: assert property (settled && !ctrl_q.dig_mode |-> port_out[1:0] == 2'b00 && !port_oe[2])
    else $error("rear port wrong in fault mode");
  fault_gate_a: assert property (settled && !ctrl_q.dig_mode
    && (!ctrl_q.flt_en || ctrl_q.flt_src == FSRC_OFF) |-> port_oe[1:0] == 2'b00)
    else $error("fault output active while disabled");
  dig_pins_a: assert property (settled && ctrl_q.dig_mode |-> port_oe[1:0] == 2'b11
    && port_out[1:0] == dig_q[1:0] && port_oe[2] == !dig_q[2])
    else $error("digital port lines wrong");
  inh_off_a: assert property (settled && ctrl_q.inh_mode == INH_OFF |-> !output_disable)
    else $error("output disabled with inhibit off");
  inh_live_a: assert property ((settled && live && $stable(port_in[2]))[*4] |-> output_disable == !port_in[2])
    else $error("live inhibit does not follow pin");
  inh_latch_a: assert property (settled && ctrl_q.inh_mode == INH_LATCHED && !ctrl_q.dig_mode
    && output_disable && !wr_done |=> output_disable)
    else $error("latched inhibit released by itself");
endmodule

bind ssr_top ssr_chk i_ssr_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .port_in(port_in),
  .port_out(port_out), .port_oe(port_oe), .srq(srq), .output_disable(output_disable));

// ==== tb/ssr_host.sv ====
// Instrument bus controller model: APB master for commands and serial polls.
// Assumes the slave raises pready; only the bench watchdog ends a wait.
module ssr_host
  import ssr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'hff;
    pwdata  = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the last request
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// ==== tb/ssr_top_tb.sv ====
// Self-checking bench of ssr_top: power cycles, status byte, filters, queue, rear port.
// Assumes the host model as APB master and pulled-up rear pins.
module ssr_top_tb
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel, penable, pwrite, pready, pslverr, srq, output_disable, keep_psc, last_err;
  logic             nv_psc = 1'b1;
  logic [7:0]       paddr, keep_std_en;
  logic [7:0]       std_events = 8'h00;
  logic [7:0]       nv_en = 8'h00;
  logic [31:0]      pwdata, prdata;
  logic [GRP_W-1:0] operation_summary_cond = '0;
  logic [GRP_W-1:0] questionable_summary_cond = '0;
  logic [DIG_W-1:0] port_in, port_out, port_oe;
  logic [DIG_W-1:0] pin_ext = 3'h7;
  int               fail_count = 0;
  int               tests_run = 0;

  always #12.5 pclk = ~pclk;
  // Open-collector pins: driven level where enabled, pull-up or outside driver elsewhere
  assign port_in = (port_oe & port_out) | (~port_oe & pin_ext);

  ssr_top i_ssr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .std_events(std_events), .operation_summary_cond_in(operation_summary_cond), .questionable_summary_cond_in(questionable_summary_cond), .saved_psc(nv_psc),
    .saved_std_en(nv_en), .keep_psc(keep_psc), .keep_std_en(keep_std_en), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .srq(srq), .output_disable(output_disable));
  ssr_host i_ssr_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic wrap_up;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_ssr_host.xfer(1'b1, a, d, q, last_err);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    logic [31:0] q;
    i_ssr_host.xfer(1'b0, a, 32'h0, q, last_err);
    chk(q & m, exp);
  endtask

  task automatic power_cycle;
    presetn <= 1'b0;
    tick(4);
    presetn <= 1'b1;
    tick(2);
  endtask

  task automatic wait_srq(input logic exp);
    int n;
    n = 0;
    while (srq !== exp && n < 10) begin
      tick(1);
      n++;
    end
    chk(32'(srq), 32'(exp));
  endtask

  task automatic t_boot;
    power_cycle;
    chk(32'(keep_psc), 32'h1);
    rd(A_STD_EN, 32'h0);
    rd(A_STD_EVT, 32'h80);
    rd(A_STD_EVT, 32'h0);
    std_events <= 8'h15;
    tick(1);
    std_events <= 8'h00;
    wr(A_STD_EN, 32'h04);
    rd(A_STD_EN, 32'h04);
    rd(A_STB, 32'h20);
    rd(A_STD_EVT, 32'h15);
    rd(A_STB, 32'h0);
    rd(8'hfc, 32'h0, 32'h0);
    chk(32'(last_err), 32'h1);
  endtask

  task automatic t_pon;
    power_cycle;
    wr(A_CTRL, 32'h48);
    wr(A_STD_EN, 32'h80);
    tick(2);
    chk(32'(keep_psc), 32'h0);
    chk(32'(keep_std_en), 32'h80);
    nv_psc <= keep_psc;
    nv_en  <= keep_std_en;
    power_cycle;
    rd(A_STD_EN, 32'h80);
    wr(A_SRQ_EN, 32'h20);
    wait_srq(1'b1);
    rd(A_STB, 32'h60);
    rd(A_STB, 32'h60);
    rd(A_SPOLL, 32'h40, 32'h40);
    wait_srq(1'b0);
    rd(A_SPOLL, 32'h0, 32'h40);
    rd(A_STB, 32'h60);
    chk(32'(srq), 32'h0);
    rd(A_STD_EVT, 32'h80);
    rd(A_STB, 32'h0);
    nv_psc <= 1'b1;
  endtask

  task automatic t_operation_summary;
    power_cycle;
    wr(A_OPERATION_SUMMARY_BASE + G_RISE, 32'h400);
    wr(A_OPERATION_SUMMARY_BASE + G_FALL, 32'h400);
    wr(A_OPERATION_SUMMARY_BASE + G_ENABLE, 32'h400);
    wr(A_SRQ_EN, 32'h80);
    operation_summary_cond[10] <= 1'b1;
    tick(6);
    rd(A_OPERATION_SUMMARY_BASE + G_COND, 32'h400);
    rd(A_STB, 32'hc0);
    rd(A_OPERATION_SUMMARY_BASE + G_EVENT, 32'h400);
    rd(A_STB, 32'h0);
    rd(A_SPOLL, 32'h40, 32'h40);
    operation_summary_cond[10] <= 1'b0;
    tick(6);
    wait_srq(1'b1);
    rd(A_OPERATION_SUMMARY_BASE + G_EVENT, 32'h400);
    rd(A_OPERATION_SUMMARY_BASE + G_COND, 32'h0);
  endtask

  task automatic t_questionable_summary;
    power_cycle;
    wr(A_QUESTIONABLE_SUMMARY_BASE + G_RISE, 32'h13);
    wr(A_QUESTIONABLE_SUMMARY_BASE + G_ENABLE, 32'h13);
    wr(A_SRQ_EN, 32'h08);
    for (int b = 0; b < 6; b++) begin
      questionable_summary_cond <= 16'h1 << b;
      tick(6);
      rd(A_STB, ((32'h13 >> b) & 32'h1) != 0 ? 32'h48 : 32'h0);
      rd(A_QUESTIONABLE_SUMMARY_BASE + G_EVENT, 32'h13 & (32'h1 << b));
      questionable_summary_cond <= 16'h0;
      tick(6);
      rd(A_STB, 32'h0);
    end
  endtask

  task automatic t_queue;
    power_cycle;
    for (int i = 1; i <= 9; i++) wr(A_QUEUE, i);
    for (int i = 1; i <= 8; i++) begin
      rd(A_STB, 32'h10);
      rd(A_QUEUE, i);
    end
    rd(A_STB, 32'h0);
    rd(A_QUEUE, 32'h0);
  endtask

  task automatic t_rear;
    power_cycle;
    chk(32'(port_oe), 32'h0);
    wr(A_STD_EN, 32'h01);
    std_events <= 8'h01;
    tick(1);
    std_events <= 8'h00;
    for (int s = 0; s < 5; s++) begin
      wr(A_CTRL, 32'h88 | (s << 4));
      tick(3);
      chk(32'(port_oe), s == 2 ? 32'h3 : 32'h0);
    end
    wr(A_CTRL, 32'h28);
    tick(3);
    chk(32'(port_oe), 32'h0);
    wr(A_SRQ_EN, 32'h20);
    wr(A_CTRL, 32'hb8);
    tick(3);
    chk(32'(port_oe), 32'h3);
    wr(A_CTRL, 32'h4a);
    for (int v = 0; v < 8; v++) begin
      wr(A_DIG_DATA, v);
      tick(4);
      rd(A_DIG_DATA, v);
    end
    wr(A_CTRL, 32'h48);
    tick(3);
    chk(32'(port_oe), 32'h0);
  endtask

  task automatic t_inhibit;
    power_cycle;
    for (int m = 0; m < 3; m++) begin
      wr(A_CTRL, 32'h40 | (m << 2));
      pin_ext[2] <= 1'b0;
      tick(6);
      chk(32'(output_disable), 32'(m != 2));
      pin_ext[2] <= 1'b1;
      tick(6);
      chk(32'(output_disable), 32'(m == 0));
      rd(A_INH_STAT, 32'(m == 0));
      wr(A_INH_STAT, 32'h1);
      tick(3);
      chk(32'(output_disable), 32'h0);
    end
  endtask

  initial begin
    t_boot;
    t_pon;
    t_operation_summary;
    t_questionable_summary;
    t_queue;
    t_rear;
    t_inhibit;
    wrap_up;
  end

  // Run needs well under a thousand cycles; this bound only catches a hang
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up;
  end
endmodule
